//--- rtl/apch_top.sv
/*
  ATS/PRI command handler top. Takes invalidation and page response
  commands from the command queue, decides send, ignore or illegal, sends
  messages to the root complex and holds sync completion until every sent
  invalidation is acknowledged.
  Assumes all inputs come from logic on i_core_clk; the root complex only
  acknowledges an invalidation once affected transactions are visible.
*/
`timescale 1ns/1ns

// Behaviour
// - Invalidation opcode 0x40 sends request covering 4096 times two to size.
// - Address bits below 12 plus size read as zero; upper bits forwarded.
// - Size 52 invalidates all; larger sizes raise the illegal error here.
// - Without PASID support, substream ignored; valid flag sends no prefix.
// - With PASID and substream valid, prefix sent; global flag only then.
// - Illegal error if feature absent, or secure block set on secure queue.
// - Invalidation ignored if system lacks ATS or queue enable is zero.
// - Both queues accepted; stream number always taken as non-secure.
// - Consuming is not completing; a later sync marks completion.
// - Complete only when affected transactions are visible in their domain.
// - An Unsupported Request answer completes the command without error.
// - Page response notifies stream of group completion with a code.
// - Page response illegal without PRI support or with reserved code.
// - Page response ignored if system lacks PRI or queue enable zero.
// - Without PASID support, page response sent without prefix.
// - With PASID support and substream valid, page response carries prefix.
module apch_top
  import apch_pkg::*;
#(
  parameter int CNT_W = 8
) (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rstn,
  // Command queue side
  input  wire logic        i_cmd_valid,
  input  wire apch_cmd_s   i_cmd,
  input  wire logic        i_cmd_secure,
  output logic             o_cmd_ready,
  output logic             o_illegal_command_error,
  output logic             o_cmd_ignored,
  // Sync side
  input  wire logic        i_sync_req,
  output logic             o_sync_done,
  // Configuration levels
  input  wire apch_cfg_s   i_cfg,
  // Root complex message side
  output logic             o_msg_valid,
  output apch_msg_s        o_msg,
  input  wire logic        i_msg_ready,
  input  wire logic        i_inval_ack,
  input  wire logic        i_inval_ack_ur,
  // Status
  output logic [CNT_W-1:0] o_outstanding
);

  // ---------------------------------------------------------------------
  // Types and state
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    APCH_ST_IDLE = 2'b00,
    APCH_ST_SEND = 2'b01,
    APCH_ST_DONE = 2'b10
  } apch_state_e;

  apch_state_e      state_reg;
  apch_state_e      state_next;
  logic             ready_reg;
  logic             ready_next;
  logic             ill_reg;
  logic             ill_next;
  logic             ign_reg;
  logic             ign_next;
  logic             msg_valid_reg;
  logic             msg_valid_next;
  apch_msg_s        msg_reg;
  apch_msg_s        msg_next;
  logic             sync_done_reg;
  logic             sync_done_next;

  apch_verdict_e    verdict;
  apch_msg_s        dec_msg;
  logic             take_cmd;
  logic             inval_sent;
  logic             ack_event;
  logic [CNT_W-1:0] count;
  logic             trk_full;
  logic             trk_empty;

  // ---------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------
  apch_decode u_decode (
    .i_cmd          (i_cmd),
    .i_secure_queue (i_cmd_secure),
    .i_cfg          (i_cfg),
    .o_verdict      (verdict),
    .o_msg          (dec_msg)
  );

  // A command is taken only when the handler is idle and ready.
  assign take_cmd   = i_cmd_valid & ready_reg & (state_reg == APCH_ST_IDLE);
  // An invalidation counts as outstanding once the root complex takes it.
  assign inval_sent = msg_valid_reg & i_msg_ready &
                      (msg_reg.kind == APCH_K_INVAL);
  // An Unsupported Request answer is still a completion, with no error.
  assign ack_event  = i_inval_ack | i_inval_ack_ur;

  // ---------------------------------------------------------------------
  // Outstanding invalidation tracking
  // ---------------------------------------------------------------------
  apch_ack_tracker #(
    .CNT_W (CNT_W)
  ) u_tracker (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_sent     (inval_sent),
    .i_ack      (ack_event),
    .o_count    (count),
    .o_full     (trk_full),
    .o_empty    (trk_empty)
  );

  // ---------------------------------------------------------------------
  // Command state machine, next values
  // ---------------------------------------------------------------------
  // Ready drops on the cycle after a take so each command is decoded once.
  // A full tracker stalls the queue rather than losing an ack count.
  always_comb begin
    state_next     = state_reg;
    ready_next     = ready_reg;
    ill_next       = 1'b0;
    ign_next       = 1'b0;
    msg_valid_next = msg_valid_reg;
    msg_next       = msg_reg;
    unique case (state_reg)
      APCH_ST_IDLE: begin
        ready_next = ~trk_full;
        if (take_cmd) begin
          ready_next = 1'b0;
          unique case (verdict)
            APCH_V_ILLEGAL: begin
              ill_next   = 1'b1;
              state_next = APCH_ST_DONE;
            end
            APCH_V_IGNORE: begin
              ign_next   = 1'b1;
              state_next = APCH_ST_DONE;
            end
            default: begin
              msg_next       = dec_msg;
              msg_valid_next = 1'b1;
              state_next     = APCH_ST_SEND;
            end
          endcase
        end
      end
      APCH_ST_SEND: begin
        if (i_msg_ready) begin
          msg_valid_next = 1'b0;
          state_next     = APCH_ST_DONE;
        end
      end
      APCH_ST_DONE: begin
        // One spare cycle lets the tracker count the send first.
        state_next = APCH_ST_IDLE;
        ready_next = ~trk_full;
      end
      default: begin
        state_next     = APCH_ST_IDLE;
        ready_next     = 1'b0;
        msg_valid_next = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------------
  // Command state machine, registers
  // ---------------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg     <= APCH_ST_IDLE;
      ready_reg     <= APCH_READY_RST;
      ill_reg       <= 1'b0;
      ign_reg       <= 1'b0;
      msg_valid_reg <= 1'b0;
      msg_reg       <= '0;
    end else begin
      state_reg     <= state_next;
      ready_reg     <= ready_next;
      ill_reg       <= ill_next;
      ign_reg       <= ign_next;
      msg_valid_reg <= msg_valid_next;
      msg_reg       <= msg_next;
    end
  end

  // ---------------------------------------------------------------------
  // Sync completion, next value
  // ---------------------------------------------------------------------
  // Sync completes only with no command in flight and no invalidation
  // awaiting its ack. The pulse is not repeated back to back, so a
  // requester that drops its request late is not completed twice.
  always_comb begin
    sync_done_next = 1'b0;
    if (i_sync_req && !sync_done_reg && state_reg == APCH_ST_IDLE &&
        !msg_valid_reg && trk_empty && !inval_sent) begin
      sync_done_next = 1'b1;
    end
  end

  // ---------------------------------------------------------------------
  // Sync completion, register
  // ---------------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync_done_reg <= 1'b0;
    end else begin
      sync_done_reg <= sync_done_next;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  // All outputs are flip-flops; the count is the tracker's own register.
  assign o_cmd_ready             = ready_reg;
  assign o_illegal_command_error = ill_reg;
  assign o_cmd_ignored           = ign_reg;
  assign o_msg_valid             = msg_valid_reg;
  assign o_msg                   = msg_reg;
  assign o_sync_done             = sync_done_reg;
  assign o_outstanding           = count;

endmodule

//--- rtl/apch_pkg.sv
/*
  Shared types and constants for the ATS/PRI command handler: command word
  layout, opcodes, field positions, response codes and the message struct.
  Assumes the command queue presents one 128-bit command as four 32-bit words.
*/
package apch_pkg;

  // ---------------------------------------------------------------------
  // Opcodes and command field positions
  // ---------------------------------------------------------------------
  localparam logic [7:0] APCH_OP_ATC_INV   = 8'h40;
  localparam logic [7:0] APCH_OP_PAGE_RESP = 8'h41;
  localparam int         APCH_OPC_LSB      = 0;
  localparam int         APCH_GLOBAL_BIT   = 9;
  localparam int         APCH_SSV_BIT      = 11;
  localparam int         APCH_SUBSTR_LSB   = 12;
  localparam int         APCH_SIZE_LSB     = 0;
  localparam int         APCH_ADDR_LSB     = 12;
  localparam int         APCH_PRG_LSB      = 0;
  localparam int         APCH_RESP_LSB     = 12;

  // ---------------------------------------------------------------------
  // Widths and limits
  // ---------------------------------------------------------------------
  localparam int         APCH_ADDR_W       = 52;
  localparam int         APCH_SUBSTR_W     = 20;
  localparam int         APCH_PRG_W        = 9;
  localparam logic [5:0] APCH_SIZE_ALL     = 6'h34;
  localparam int         APCH_PAGE_SHIFT   = 12;

  // ---------------------------------------------------------------------
  // Page response codes
  // ---------------------------------------------------------------------
  localparam logic [1:0] APCH_RESP_FAILURE = 2'h0;
  localparam logic [1:0] APCH_RESP_INVALID = 2'h1;
  localparam logic [1:0] APCH_RESP_SUCCESS = 2'h2;
  localparam logic [1:0] APCH_RESP_RSVD    = 2'h3;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic       APCH_READY_RST    = 1'b1;

  typedef enum logic [1:0] {
    APCH_V_SEND    = 2'b00,
    APCH_V_IGNORE  = 2'b01,
    APCH_V_ILLEGAL = 2'b10
  } apch_verdict_e;

  typedef enum logic {
    APCH_K_INVAL = 1'b0,
    APCH_K_PRESP = 1'b1
  } apch_kind_e;

  typedef struct packed {
    logic [31:0] w3;
    logic [31:0] w2;
    logic [31:0] w1;
    logic [31:0] w0;
  } apch_cmd_s;

  typedef struct packed {
    logic ats_supported;
    logic pri_supported;
    logic pasid_supported;
    logic secure_queue_ats_block;
    logic system_ats_ok;
    logic system_pri_ok;
    logic translation_enable_ns;
    logic translation_enable_s;
  } apch_cfg_s;

  typedef struct packed {
    apch_kind_e               kind;
    logic [31:0]              stream_number;
    logic                     pasid_en;
    logic [APCH_SUBSTR_W-1:0] pasid;
    logic                     global_inv;
    logic                     inval_all;
    logic [APCH_ADDR_W-1:0]   addr;
    logic [5:0]               size;
    logic [APCH_PRG_W-1:0]    page_group_index;
    logic [1:0]               resp;
  } apch_msg_s;

endpackage

//--- rtl/apch_decode.sv
/*
  Combinational decoder: turns one command into a verdict (send, ignore,
  illegal) and the outgoing message. Assumes configuration inputs are
  stable, same-clock levels.
*/
`timescale 1ns/1ns
module apch_decode
  import apch_pkg::*;
(
  // Command
  input  wire apch_cmd_s     i_cmd,
  input  wire logic          i_secure_queue,
  // Configuration
  input  wire apch_cfg_s     i_cfg,
  // Result
  output apch_verdict_e      o_verdict,
  output apch_msg_s          o_msg
);

  // ---------------------------------------------------------------------
  // Address alignment
  // ---------------------------------------------------------------------
  // Clears address bits below 12 plus size; size 52 and above clears all.
  function automatic logic [APCH_ADDR_W-1:0] align_addr(
    input logic [APCH_ADDR_W-1:0] addr,
    input logic [5:0]             size
  );
    logic [APCH_ADDR_W-1:0] keep;
    keep = '1;
    if (size >= APCH_SIZE_ALL) begin
      keep = '0;
    end else begin
      keep = keep << size;
    end
    return addr & keep;
  endfunction

  logic [7:0] opcode;
  logic       substream_valid;
  logic [5:0] size;
  logic [1:0] resp;
  logic       te;

  assign opcode = i_cmd.w0[APCH_OPC_LSB +: 8];
  assign substream_valid    = i_cmd.w0[APCH_SSV_BIT];
  assign size   = i_cmd.w2[APCH_SIZE_LSB +: 6];
  assign resp   = i_cmd.w2[APCH_RESP_LSB +: 2];
  // The enable of the issuing queue gates the command.
  assign te     = i_secure_queue ? i_cfg.translation_enable_s
                                 : i_cfg.translation_enable_ns;

  // ---------------------------------------------------------------------
  // Verdict and message
  // ---------------------------------------------------------------------
  // Illegal cases are checked before the ignore cases.
  always_comb begin
    o_msg                  = '0;
    o_msg.stream_number    = i_cmd.w1;
    o_msg.pasid            = i_cmd.w0[APCH_SUBSTR_LSB +: APCH_SUBSTR_W];
    o_msg.pasid_en         = substream_valid & i_cfg.pasid_supported;
    if (!o_msg.pasid_en) begin
      o_msg.pasid = '0;
    end
    o_verdict = APCH_V_SEND;
    if (opcode == APCH_OP_ATC_INV) begin
      o_msg.kind       = APCH_K_INVAL;
      o_msg.size       = size;
      o_msg.addr       = align_addr({i_cmd.w3, i_cmd.w2[31:APCH_ADDR_LSB]},
                                    size);
      o_msg.inval_all  = (size == APCH_SIZE_ALL);
      o_msg.global_inv = o_msg.pasid_en & i_cmd.w0[APCH_GLOBAL_BIT];
      if (!i_cfg.ats_supported) begin
        o_verdict = APCH_V_ILLEGAL;
      end else if (i_cfg.secure_queue_ats_block && i_secure_queue) begin
        o_verdict = APCH_V_ILLEGAL;
      end else if (size > APCH_SIZE_ALL) begin
        o_verdict = APCH_V_ILLEGAL;
      end else if (!i_cfg.system_ats_ok || !te) begin
        o_verdict = APCH_V_IGNORE;
      end
    end else if (opcode == APCH_OP_PAGE_RESP) begin
      o_msg.kind             = APCH_K_PRESP;
      o_msg.resp             = resp;
      o_msg.page_group_index = i_cmd.w2[APCH_PRG_LSB +: APCH_PRG_W];
      if (!i_cfg.pri_supported || resp == APCH_RESP_RSVD) begin
        o_verdict = APCH_V_ILLEGAL;
      end else if (i_cfg.secure_queue_ats_block && i_secure_queue) begin
        o_verdict = APCH_V_ILLEGAL;
      end else if (!i_cfg.system_pri_ok || !te) begin
        o_verdict = APCH_V_IGNORE;
      end
    end else begin
      o_verdict = APCH_V_ILLEGAL;
    end
  end

endmodule

//--- rtl/apch_ack_tracker.sv
/*
  Counts invalidation requests sent but not yet acknowledged by the root
  complex. Assumes acknowledgements arrive as one-cycle same-clock pulses,
  never more than were sent.
*/
`timescale 1ns/1ns
module apch_ack_tracker
  import apch_pkg::*;
#(
  parameter int CNT_W = 8
) (
  // Clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_rstn,
  // Events
  input  wire logic             i_sent,
  input  wire logic             i_ack,
  // State
  output logic [CNT_W-1:0]      o_count,
  output logic                  o_full,
  output logic                  o_empty
);

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;

  // ---------------------------------------------------------------------
  // Outstanding count
  // ---------------------------------------------------------------------
  // A send and an ack in the same cycle cancel; nothing is lost.
  always_comb begin
    count_next = count_reg;
    if (i_sent && !i_ack) begin
      count_next = count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end else if (!i_sent && i_ack && count_reg != '0) begin
      count_next = count_reg - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign o_count = count_reg;
  assign o_full  = (count_reg == '1);
  assign o_empty = (count_reg == '0);

endmodule

//--- tb/apch_top_props.sv
/*
  Port checker for apch_top: answer timing, verdicts, message fields.
  Assumes binding into apch_top and a still configuration per command.
*/
`timescale 1ns/1ns
module apch_top_props
  import apch_pkg::*;
#(
  parameter int CNT_W = 8
) (
  // Clock and reset
  input wire logic             i_core_clk,
  input wire logic             i_rstn,
  // Command, sync and configuration
  input wire logic             i_cmd_valid,
  input wire apch_cmd_s        i_cmd,
  input wire logic             i_cmd_secure,
  input wire logic             o_cmd_ready,
  input wire logic             o_illegal_command_error,
  input wire logic             o_cmd_ignored,
  input wire logic             i_sync_req,
  input wire logic             o_sync_done,
  input wire apch_cfg_s        i_cfg,
  // Root complex side
  input wire logic             o_msg_valid,
  input wire apch_msg_s        o_msg,
  input wire logic             i_msg_ready,
  input wire logic             i_inval_ack,
  input wire logic             i_inval_ack_ur,
  input wire logic [CNT_W-1:0] o_outstanding
);
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  logic                   take_inv;
  logic                   take_pr;
  logic                   q_en;
  logic [APCH_ADDR_W-1:0] low_mask;

  // Take decode and span mask.
  always_comb begin
    take_inv = i_cmd_valid && o_cmd_ready && i_cmd.w0[7:0] == APCH_OP_ATC_INV;
    take_pr = i_cmd_valid && o_cmd_ready && i_cmd.w0[7:0] == APCH_OP_PAGE_RESP;
    q_en = i_cmd_secure ? i_cfg.translation_enable_s
                        : i_cfg.translation_enable_ns;
    low_mask = (52'h1 << o_msg.size) - 52'h1;
  end

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);

  sequence s_take;
    i_cmd_valid && o_cmd_ready;
  endsequence
  sequence s_answer;
    !o_cmd_ready && $onehot({o_illegal_command_error, o_cmd_ignored,
                             o_msg_valid});
  endsequence
  sequence s_inv_quiet;
    take_inv && i_cfg.ats_supported && i_cmd.w2[5:0] <= APCH_SIZE_ALL &&
    !(i_cfg.secure_queue_ats_block && i_cmd_secure) &&
    !(i_cfg.system_ats_ok && q_en);
  endsequence

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  a_cmd_answered: assert property (s_take |=> s_answer)
    else $error("no single answer");
  a_inv_illegal: assert property (take_inv && (!i_cfg.ats_supported ||
    (i_cfg.secure_queue_ats_block && i_cmd_secure)) |=>
    o_illegal_command_error) else $error("inval not illegal");
  a_resp_illegal: assert property (take_pr &&
    i_cmd.w2[13:12] == APCH_RESP_RSVD |=> o_illegal_command_error)
    else $error("reserved code taken");
  a_inv_ignored: assert property (s_inv_quiet |=> o_cmd_ignored)
    else $error("inval not ignored");
  a_msg_held: assert property (o_msg_valid && !i_msg_ready |=>
    o_msg_valid && $stable(o_msg)) else $error("message withdrawn");
  a_global_prefix: assert property (o_msg_valid && o_msg.global_inv |->
    o_msg.pasid_en) else $error("global, no prefix");
  a_no_prefix: assert property (o_msg_valid &&
    !i_cfg.pasid_supported |-> !o_msg.pasid_en)
    else $error("prefix without support");
  a_addr_aligned: assert property (o_msg_valid &&
    o_msg.kind == APCH_K_INVAL && !o_msg.inval_all |->
    (o_msg.addr & low_mask) == '0) else $error("address not aligned");
  a_inval_all: assert property (o_msg_valid &&
    o_msg.kind == APCH_K_INVAL && o_msg.size == APCH_SIZE_ALL |->
    o_msg.inval_all && o_msg.addr == '0) else $error("full span wrong");
  a_sync_clear: assert property (o_sync_done |->
    o_outstanding == '0 && !$past(o_sync_done))
    else $error("early sync");
  a_ur_counts: assert property (i_inval_ack_ur && !i_inval_ack &&
    o_outstanding != '0 && !(o_msg_valid && i_msg_ready) |=>
    o_outstanding == $past(o_outstanding) - 1'b1 && !o_illegal_command_error)
    else $error("UR not counted");
endmodule

bind apch_top apch_top_props #(.CNT_W(CNT_W)) u_props (.*);

//--- tb/apch_rc_model.sv
/*
  Root complex model: takes messages, later acks each invalidation.
  Assumes one clock; drives on the falling edge.
*/
`timescale 1ns/1ns
module apch_rc_model
  import apch_pkg::*;
(
  // Clock and reset
  input  wire logic      i_core_clk,
  input  wire logic      i_rstn,
  // Controls from the bench
  input  wire logic      i_slow,
  input  wire logic      i_hold,
  input  wire logic      i_use_ur,
  // Message side
  input  wire logic      i_msg_valid,
  input  wire apch_msg_s i_msg,
  output logic           o_msg_ready,
  output logic           o_ack,
  output logic           o_ack_ur
);
  int   pend;
  logic fire;

  // Invalidations taken, not yet acked.
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pend <= 0;
    end else begin
      pend <= pend - int'(o_ack || o_ack_ur) +
              int'(i_msg_valid && o_msg_ready && i_msg.kind == APCH_K_INVAL);
    end
  end

  // Acks follow takes only, so affected traffic is visible.
  always @(negedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      {o_msg_ready, o_ack, o_ack_ur} <= '0;
    end else begin
      fire = pend > int'(o_ack || o_ack_ur) && !i_hold &&
             $urandom_range(2) == 0;
      o_msg_ready <= !i_slow || $urandom_range(3) == 0;
      o_ack <= fire && !i_use_ur;
      o_ack_ur <= fire && i_use_ur;
    end
  end
endmodule

//--- tb/apch_tb_top.sv
/*
  Self-checking bench for apch_top and a root complex model.
  Assumes an answer one cycle after each take.
*/
`timescale 1ns/1ns
module apch_tb_top
  import apch_pkg::*;
;
  localparam int CNT_W = 2;
  logic clk, rstn, cmd_valid, cmd_secure, cmd_ready, ill_err, ignored;
  logic sync_req, sync_done, msg_valid, msg_ready, ack, ack_ur, hs_seen;
  logic slow, hold, use_ur;
  apch_cmd_s cmd;
  apch_cfg_s cfg;
  apch_msg_s msg, hs_msg;
  logic [CNT_W-1:0] outstanding;
  int failures, compares;

  apch_top #(.CNT_W(CNT_W)) i_dut (
    .i_core_clk(clk), .i_rstn(rstn), .i_cmd_valid(cmd_valid), .i_cmd(cmd),
    .i_cmd_secure(cmd_secure), .o_cmd_ready(cmd_ready),
    .o_illegal_command_error(ill_err), .o_cmd_ignored(ignored),
    .i_sync_req(sync_req), .o_sync_done(sync_done), .i_cfg(cfg),
    .o_msg_valid(msg_valid), .o_msg(msg), .i_msg_ready(msg_ready),
    .i_inval_ack(ack), .i_inval_ack_ur(ack_ur), .o_outstanding(outstanding)
  );
  apch_rc_model i_rc (
    .i_core_clk(clk), .i_rstn(rstn), .i_slow(slow), .i_hold(hold),
    .i_use_ur(use_ur), .i_msg_valid(msg_valid), .i_msg(msg),
    .o_msg_ready(msg_ready), .o_ack(ack), .o_ack_ur(ack_ur)
  );

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Record each message at the edge where the root complex takes it.
  always @(posedge clk) begin
    hs_msg <= msg;
    hs_seen <= msg_valid && msg_ready;
  end

  function automatic apch_verdict_e exp_v(apch_cmd_s c, logic s,
                                          apch_cfg_s f);
    logic en;
    logic blk;
    en = s ? f.translation_enable_s : f.translation_enable_ns;
    blk = f.secure_queue_ats_block && s;
    if (c.w0[7:0] == APCH_OP_ATC_INV) begin
      if (!f.ats_supported || blk || c.w2[5:0] > APCH_SIZE_ALL)
        return APCH_V_ILLEGAL;
      return (f.system_ats_ok && en) ? APCH_V_SEND : APCH_V_IGNORE;
    end
    if (c.w0[7:0] == APCH_OP_PAGE_RESP) begin
      if (!f.pri_supported || blk || c.w2[13:12] == APCH_RESP_RSVD)
        return APCH_V_ILLEGAL;
      return (f.system_pri_ok && en) ? APCH_V_SEND : APCH_V_IGNORE;
    end
    return APCH_V_ILLEGAL;
  endfunction

  function automatic apch_msg_s exp_m(apch_cmd_s c, apch_cfg_s f);
    apch_msg_s m;
    m = '0;
    m.stream_number = c.w1;
    m.pasid_en = c.w0[11] & f.pasid_supported;
    m.pasid = m.pasid_en ? c.w0[31:12] : '0;
    if (c.w0[7:0] == APCH_OP_PAGE_RESP) begin
      m.kind = APCH_K_PRESP;
      m.page_group_index = c.w2[8:0];
      m.resp = c.w2[13:12];
      return m;
    end
    m.global_inv = m.pasid_en & c.w0[9];
    m.size = c.w2[5:0];
    m.inval_all = m.size == APCH_SIZE_ALL;
    m.addr = {c.w3, c.w2[31:12]} & ~((52'h1 << m.size) - 52'h1);
    return m;
  endfunction

  task automatic chk_b(string nm, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chk_m(apch_msg_s e, apch_msg_s g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("[ERR] message exp %h got %h", e, g);
    end
  endtask

  task automatic test_done();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // One command: wait for ready, check the answer, then the message.
  task automatic run(apch_cmd_s c, logic s, apch_cfg_s f);
    apch_verdict_e v;
    int n;
    v = exp_v(c, s, f);
    n = 0;
    @(negedge clk);
    cfg = f;
    cmd = c;
    cmd_secure = s;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    chk_b("answer", 8'({v == APCH_V_ILLEGAL, v == APCH_V_IGNORE,
          v == APCH_V_SEND}), 8'({ill_err, ignored, msg_valid}));
    if (v == APCH_V_SEND) begin
      while (hs_seen !== 1'b1 && n < 600) begin
        @(negedge clk);
        n++;
      end
      chk_m(exp_m(c, f), hs_msg);
    end
  endtask

  // Watchdog; the run needs a few hundred cycles.
  initial begin
    #400000;
    failures++;
    $display("[ERR] watchdog exp done got hang");
    test_done();
  end

  initial begin
    logic [5:0] sz [4];
    apch_cmd_s c;
    int n;
    sz = '{6'h00, 6'h33, 6'h34, 6'h35};
    {rstn, cmd_valid, cmd_secure, sync_req, slow, hold, use_ur} = '0;
    cmd = '0;
    cfg = '0;
    void'($urandom(32'h8248EA23));
    repeat (8) @(posedge clk);
    chk_b("reset outputs", 8'h10,
          8'({cmd_ready, ill_err, ignored, msg_valid, sync_done}));
    @(negedge clk);
    rstn = 1'b1;
    // Span boundaries, every response code, global with and without prefix.
    for (int i = 0; i < 8; i++) begin
      c = {$urandom, $urandom, $urandom, $urandom};
      c.w0[7:0] = (i < 4) ? APCH_OP_ATC_INV : APCH_OP_PAGE_RESP;
      c.w0[11] = i[0];
      c.w0[9] = 1'b1;
      c.w2[5:0] = sz[i % 4];
      c.w2[13:12] = 2'(i);
      run(c, 1'b0, apch_cfg_s'(8'hEF));
    end
    // Blocked secure queue, no PASID support, unknown opcode.
    for (int i = 0; i < 3; i++) begin
      c = {$urandom, $urandom, $urandom, $urandom};
      c.w0[7:0] = (i == 2) ? 8'h7E : APCH_OP_ATC_INV;
      c.w0[11] = 1'b1;
      c.w2[5:0] = 6'h05;
      run(c, i == 0, apch_cfg_s'(i == 0 ? 8'hFF : 8'hCF));
    end
    $display("test corner done");
    for (int i = 0; i < 120; i++) begin
      c = {$urandom, $urandom, $urandom, $urandom};
      n = $urandom_range(5);
      c.w0[7:0] = n < 3 ? APCH_OP_ATC_INV : n < 5 ? APCH_OP_PAGE_RESP
                : 8'($urandom);
      slow = 1'($urandom);
      run(c, 1'($urandom), apch_cfg_s'(8'($urandom | $urandom)));
    end
    $display("test random done");
    // Hold acks to fill the tracker, then release them as unsupported.
    n = 0;
    while (outstanding != '0 && n < 500) begin
      @(negedge clk);
      n++;
    end
    {hold, use_ur, slow} = 3'h6;
    for (int i = 0; i < 3; i++) begin
      c = {$urandom, $urandom, $urandom, $urandom};
      c.w0[7:0] = APCH_OP_ATC_INV;
      c.w2[5:0] = 6'h00;
      run(c, 1'b0, apch_cfg_s'(8'hEF));
    end
    repeat (3) @(negedge clk);
    chk_b("full ready", 8'h00, 8'(cmd_ready));
    chk_b("held count", 8'h03, 8'(outstanding));
    sync_req = 1'b1;
    n = 0;
    repeat (20) begin
      @(negedge clk);
      n += int'(sync_done);
    end
    chk_b("early sync", 8'h00, 8'(n));
    hold = 1'b0;
    n = 0;
    while (sync_done !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    sync_req = 1'b0;
    chk_b("sync done", 8'h01, 8'(sync_done));
    chk_b("drained", 8'h00, 8'(outstanding));
    $display("test sync done");
    test_done();
  end
endmodule
